// ---- design/tag_pkg.sv ----
// constants, enumerations and carrier types of the timer alarm group
// assumes a 32-bit timer count on the same clock as the alarm logic
package tag_pkg;

	localparam int CNT_W = 32;

	// register map, byte addresses on the plain register port
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_COUNT  = 8'h04;
	// channel n (1..4) sits at n * 0x10; word select in addr[3:2]
	localparam logic [1:0] SEL_CFG   = 2'h0;
	localparam logic [1:0] SEL_CTRL  = 2'h1;
	localparam logic [1:0] SEL_MATCH = 2'h2;
	localparam logic [1:0] SEL_PULSE = 2'h3;

	// field positions
	localparam int CFG_STYLE_LSB   = 0;
	localparam int CFG_CYCLIC_BIT  = 4;
	localparam int CTRL_ARM_BIT    = 0;
	localparam int CTRL_DISARM_BIT = 4;
	localparam int CTRL_APPLY_BIT  = 15;
	localparam int STAT_ALARM_LSB  = 8;

	// values after reset
	localparam logic [CNT_W-1:0] RST_MATCH = 32'h0000_0000;
	localparam logic [CNT_W-1:0] RST_PULSE = 32'h0000_0000;
	localparam logic [31:0]      RST_RDATA = 32'h0000_0000;

	typedef enum logic [1:0] {
		STYLE_ABS  = 2'h0,
		STYLE_REL  = 2'h1,
		STYLE_COMB = 2'h2,
		STYLE_RSVD = 2'h3
	} tag_style_t;

	// gray along idle -> absolute wait -> relative wait -> hold
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ABS  = 2'h1,
		ST_REL  = 2'h3,
		ST_HOLD = 2'h2
	} tag_state_t;

	typedef struct packed {
		logic             cyclic;
		tag_style_t       style;
		logic [CNT_W-1:0] match;
		logic [CNT_W-1:0] pulse;
		logic             pend;
	} tag_cfg_t;

endpackage

// ---- design/tag_rise_detect.sv ----
// one-cycle event on each rising edge of a vector of levels
// assumes the levels come from flops on the same clock
`timescale 1ns/1ns
`default_nettype none
module tag_rise_detect #(
	parameter int N = 4
) (
	input  wire logic         mclk,    // block clock
	input  wire logic         reset_n, // async reset, active low
	input  wire logic [N-1:0] level,   // alarm levels
	output logic      [N-1:0] rise     // one-cycle rise events
);

	logic [N-1:0] prev;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prev <= '0;
			rise <= '0;
		end else begin
			prev <= level;
			rise <= level & ~prev;
		end
	end

	default clocking dc @(posedge mclk); endclocking
	default disable iff (!reset_n);

	a_rise_event: assert property (
		(level & ~$past(level)) != '0 |=> rise != '0)
		else $error("rise of an alarm level gave no event");
	a_no_fall_event: assert property (
		(level == '0) |=> rise == '0)
		else $error("event raised without a rising edge");

endmodule
`default_nettype wire

// ---- design/tag_channel.sv ----
// one alarm channel: match engine, pulse timer, active settings
// assumes the timer count changes by one per count step, same clock
`timescale 1ns/1ns
`default_nettype none
module tag_channel (
	input  wire logic                    mclk,    // block clock
	input  wire logic                    reset_n, // async reset, low
	input  wire logic [tag_pkg::CNT_W-1:0] count, // timer count
	input  wire logic                    arm,     // arm strobe pulse
	input  wire logic                    disarm,  // disarm strobe pulse
	input  wire tag_pkg::tag_cfg_t       cfg,     // stored settings
	output logic                         enabled, // channel armed
	output logic                         applied, // stored set taken
	output logic                         alarm    // alarm level
);

	tag_pkg::tag_state_t        state;
	tag_pkg::tag_state_t        next_state;
	logic [tag_pkg::CNT_W-1:0]  prevCount;
	logic [tag_pkg::CNT_W-1:0]  activeMatch;
	logic [tag_pkg::CNT_W-1:0]  activePulse;
	logic [tag_pkg::CNT_W-1:0]  refCount;
	logic [tag_pkg::CNT_W-1:0]  remain;
	logic [tag_pkg::CNT_W-1:0]  elapsed;
	logic [tag_pkg::CNT_W-1:0]  firePulse;
	logic                       tick;
	logic                       hitAbs;
	logic                       hitRel;
	logic                       fire;
	logic                       armNow;
	logic                       follow;

	assign tick    = count != prevCount;
	assign elapsed = count - refCount;
	assign hitAbs  = tick && count == activeMatch;
	assign hitRel  = tick && elapsed == activeMatch;
	assign fire    = (state == tag_pkg::ST_ABS && hitAbs) ||
	                 (state == tag_pkg::ST_REL && hitRel);
	assign armNow  = arm && !disarm;
	assign applied = armNow || (fire && cfg.pend && !disarm);
	assign follow  = state == tag_pkg::ST_IDLE || applied;
	assign firePulse = (fire && cfg.pend) ? cfg.pulse : activePulse;
	assign enabled = state != tag_pkg::ST_IDLE;

	always_comb begin
		next_state = state;
		unique case (state)
			tag_pkg::ST_IDLE: next_state = tag_pkg::ST_IDLE;
			tag_pkg::ST_ABS: if (fire) begin
				if (cfg.style == tag_pkg::STYLE_COMB)
					next_state = tag_pkg::ST_REL;
				else if (!cfg.cyclic)
					next_state = tag_pkg::ST_HOLD;
			end
			tag_pkg::ST_REL: if (fire && !cfg.cyclic)
				next_state = tag_pkg::ST_HOLD;
			tag_pkg::ST_HOLD: next_state = tag_pkg::ST_HOLD;
		endcase
		if (armNow) begin
			unique case (cfg.style)
				tag_pkg::STYLE_ABS:  next_state = tag_pkg::ST_ABS;
				tag_pkg::STYLE_COMB: next_state = tag_pkg::ST_ABS;
				tag_pkg::STYLE_REL:  next_state = tag_pkg::ST_REL;
				tag_pkg::STYLE_RSVD: next_state = tag_pkg::ST_HOLD;
			endcase
		end
		if (disarm)
			next_state = tag_pkg::ST_IDLE;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state       <= tag_pkg::ST_IDLE;
			prevCount   <= '0;
			activeMatch <= tag_pkg::RST_MATCH;
			activePulse <= tag_pkg::RST_PULSE;
			refCount    <= '0;
		end else begin
			state     <= next_state;
			prevCount <= count;
			if (follow) begin
				activeMatch <= cfg.match;
				activePulse <= cfg.pulse;
			end
			if (armNow || fire)
				refCount <= count;
		end
	end

	// pulse length counts timer steps, not block clocks
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			remain <= '0;
			alarm  <= 1'b0;
		end else if (disarm || armNow) begin
			remain <= '0;
			alarm  <= 1'b0;
		end else if (fire) begin
			remain <= firePulse;
			alarm  <= firePulse != '0;
		end else if (tick && remain != '0) begin
			remain <= remain - 1'b1;
			alarm  <= remain != 32'h0000_0001;
		end
	end

	default clocking dc @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence sArm;
		arm && !disarm;
	endsequence
	sequence sAbsFire;
		state == tag_pkg::ST_ABS && hitAbs && !disarm && !arm;
	endsequence

	a_arm_enables: assert property (
		sArm |=> enabled ##0 activeMatch == $past(cfg.match))
		else $error("arm did not enable or load match");
	a_disarm_clears: assert property (
		disarm |=> !enabled && !alarm)
		else $error("disarm left channel or alarm on");
	a_abs_pulse: assert property (
		sAbsFire ##0 firePulse != '0 |=> alarm)
		else $error("absolute match did not raise alarm");
	a_comb_to_rel: assert property (
		sAbsFire ##0 cfg.style == tag_pkg::STYLE_COMB
		|=> state == tag_pkg::ST_REL && refCount == $past(count))
		else $error("combined mode did not switch to relative");
	a_rel_reload: assert property (
		state == tag_pkg::ST_REL && hitRel && cfg.cyclic && !arm && !disarm
		|=> state == tag_pkg::ST_REL && refCount == $past(count))
		else $error("cyclic relative reference not reloaded");
	a_pulse_end: assert property (
		alarm && tick && remain == 32'h0000_0001 && !fire && !arm
		&& !disarm |=> !alarm)
		else $error("alarm outlived its pulse length");
	a_defer_write: assert property (
		enabled && !applied |=> $stable(activeMatch) && $stable(activePulse))
		else $error("active settings changed while enabled");
	a_fire_apply: assert property (
		fire && cfg.pend && !disarm && !arm
		|=> activePulse == $past(cfg.pulse) &&
		activeMatch == $past(cfg.match))
		else $error("pending settings not applied at fire");
	a_idle_follow: assert property (
		!enabled |=> activeMatch == $past(cfg.match))
		else $error("disabled channel ignored a write");

endmodule
`default_nettype wire

// ---- design/tag_alarm_group.sv ----
// timer alarm group: register port, per-channel storage, four channels
// assumes timerCount comes from the timer on mclk, so no synchroniser
`timescale 1ns/1ns
`default_nettype none
module tag_alarm_group #(
	parameter int NCH = 4
) (
	input  wire logic       mclk,       // block clock, 50 MHz
	input  wire logic       reset_n,    // async reset, active low
	input  wire logic [7:0] addr,       // register byte address
	input  wire logic [31:0] wrData,    // register write data
	input  wire logic       wrStrobe,   // one-cycle write strobe
	input  wire logic       rdStrobe,   // one-cycle read strobe
	input  wire logic [31:0] timerCount, // running timer count
	output logic [31:0]     rdData,     // read data, cycle after strobe
	output logic [NCH-1:0]  alarmOut,   // alarm levels, GPIO route
	output logic [NCH-1:0]  alarmEvent  // rise events to irq control
);

	// index stays one bit wide even for a single channel
	localparam int IW = (NCH > 1) ? $clog2(NCH) : 1;

	// decoded write of one channel word
	function automatic logic chanWr(
		input logic          strobe,
		input logic          hit,
		input logic [IW-1:0] idx,
		input logic [1:0]    sel,
		input int            ch,
		input logic [1:0]    want
	);
		chanWr = strobe && hit && idx == IW'(ch) && sel == want;
	endfunction

	logic [2:0]        chanField;
	logic              chanHit;
	logic [IW-1:0]     chanIdx;
	logic [1:0]        regSel;
	logic [31:0]       statusWord;
	logic [31:0]       chanWord;
	logic [31:0]       next_rdData;

	logic                       cyclic      [NCH];
	tag_pkg::tag_style_t        style       [NCH];
	logic [tag_pkg::CNT_W-1:0]  storedMatch [NCH];
	logic [tag_pkg::CNT_W-1:0]  storedPulse [NCH];
	logic [NCH-1:0]             pend;
	logic [NCH-1:0]             armVec;
	logic [NCH-1:0]             disarmVec;
	logic [NCH-1:0]             enabledVec;
	logic [NCH-1:0]             appliedVec;
	logic [NCH-1:0]             alarmLvl;
	tag_pkg::tag_cfg_t          cfgVec      [NCH];

	// only word-aligned words of existing channels decode
	assign chanField = addr[6:4];
	assign regSel    = addr[3:2];
	assign chanHit   = !addr[7] && chanField != 3'h0 &&
	                   32'(chanField) <= NCH && addr[1:0] == 2'h0;
	assign chanIdx   = IW'(chanField - 3'h1);

	// stored copies here; each engine keeps its own active set
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : gCh
			logic cfgWr;
			logic ctrlWr;
			logic matchWr;
			logic pulseWr;

			assign cfgWr   = chanWr(wrStrobe, chanHit, chanIdx, regSel, g,
			                        tag_pkg::SEL_CFG);
			assign ctrlWr  = chanWr(wrStrobe, chanHit, chanIdx, regSel, g,
			                        tag_pkg::SEL_CTRL);
			assign matchWr = chanWr(wrStrobe, chanHit, chanIdx, regSel, g,
			                        tag_pkg::SEL_MATCH);
			assign pulseWr = chanWr(wrStrobe, chanHit, chanIdx, regSel, g,
			                        tag_pkg::SEL_PULSE);
			assign armVec[g]    = ctrlWr && wrData[tag_pkg::CTRL_ARM_BIT];
			assign disarmVec[g] = ctrlWr && wrData[tag_pkg::CTRL_DISARM_BIT];

			assign cfgVec[g] = '{cyclic: cyclic[g], style: style[g],
			                     match: storedMatch[g],
			                     pulse: storedPulse[g], pend: pend[g]};

			always_ff @(posedge mclk or negedge reset_n) begin
				if (!reset_n) begin
					cyclic[g]      <= 1'b0;
					style[g]       <= tag_pkg::STYLE_ABS;
					storedMatch[g] <= tag_pkg::RST_MATCH;
					storedPulse[g] <= tag_pkg::RST_PULSE;
				end else begin
					if (cfgWr) begin
						cyclic[g] <= wrData[tag_pkg::CFG_CYCLIC_BIT];
						style[g]  <= tag_pkg::tag_style_t'(
						             wrData[tag_pkg::CFG_STYLE_LSB +: 2]);
					end
					if (matchWr)
						storedMatch[g] <= wrData;
					if (pulseWr)
						storedPulse[g] <= wrData;
				end
			end

			// set wins over the clear by an apply in the same cycle
			always_ff @(posedge mclk or negedge reset_n) begin
				if (!reset_n)
					pend[g] <= 1'b0;
				else if (ctrlWr && wrData[tag_pkg::CTRL_APPLY_BIT] &&
				         enabledVec[g])
					pend[g] <= 1'b1;
				else if (appliedVec[g])
					pend[g] <= 1'b0;
			end

			tag_channel uChan (
				.mclk    (mclk),
				.reset_n (reset_n),
				.count   (timerCount),
				.arm     (armVec[g]),
				.disarm  (disarmVec[g]),
				.cfg     (cfgVec[g]),
				.enabled (enabledVec[g]),
				.applied (appliedVec[g]),
				.alarm   (alarmLvl[g])
			);
		end
	endgenerate

	// level straight from the channel flop
	assign alarmOut = alarmLvl;

	// edge events for the interrupt controller
	tag_rise_detect #(
		.N (NCH)
	) uRise (
		.mclk    (mclk),
		.reset_n (reset_n),
		.level   (alarmLvl),
		.rise    (alarmEvent)
	);

	// status: enables from bit 0, alarm levels from bit 8
	assign statusWord = 32'({alarmLvl, 8'(enabledVec)} &
	                    {{NCH{1'b1}}, 8'hFF}) << 0;
	// reads show what software stored, so a deferred write is visible
	assign chanWord =
		regSel == tag_pkg::SEL_CFG   ? 32'({cyclic[chanIdx], 2'h0,
		                                    style[chanIdx]}) :
		regSel == tag_pkg::SEL_CTRL  ? 32'(pend[chanIdx])
		                               << tag_pkg::CTRL_APPLY_BIT :
		regSel == tag_pkg::SEL_MATCH ? storedMatch[chanIdx] :
		                               storedPulse[chanIdx];
	// unmapped addresses read as zero
	assign next_rdData =
		addr == tag_pkg::ADDR_STATUS ? statusWord :
		addr == tag_pkg::ADDR_COUNT  ? timerCount :
		chanHit                      ? chanWord   :
		                               32'h0000_0000;

	// data stand only in the cycle after the strobe
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			rdData <= tag_pkg::RST_RDATA;
		else
			rdData <= rdStrobe ? next_rdData : 32'h0000_0000;
	end

	default clocking dc @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// bus decodes shared by the register checks
	sequence sChanWr;
		wrStrobe && chanHit;
	endsequence

	sequence sChanRd;
		rdStrobe && chanHit;
	endsequence

	sequence sCtrlWr;
		sChanWr ##0 regSel == tag_pkg::SEL_CTRL;
	endsequence

	// answers stand only in the cycle after the read strobe
	a_read_window: assert property (
		!rdStrobe |=> rdData == 32'h0000_0000)
		else $error("read data outside the answer cycle");
	a_unmapped_zero: assert property (
		rdStrobe && !chanHit && addr != tag_pkg::ADDR_STATUS &&
		addr != tag_pkg::ADDR_COUNT |=> rdData == 32'h0000_0000)
		else $error("unmapped address read as nonzero");
	a_status_word: assert property (
		rdStrobe && addr == tag_pkg::ADDR_STATUS
		|=> rdData[NCH-1:0] == $past(enabledVec) &&
		rdData[tag_pkg::STAT_ALARM_LSB +: NCH] == $past(alarmLvl))
		else $error("status word does not show the channels");
	a_count_word: assert property (
		rdStrobe && addr == tag_pkg::ADDR_COUNT
		|=> rdData == $past(timerCount))
		else $error("count word differs from the timer count");
	a_cfg_word: assert property (
		sChanRd ##0 regSel == tag_pkg::SEL_CFG
		|=> rdData[tag_pkg::CFG_CYCLIC_BIT] == $past(cyclic[chanIdx]) &&
		rdData[tag_pkg::CFG_STYLE_LSB +: 2] == $past(style[chanIdx]))
		else $error("mode word read back wrongly");
	a_pend_word: assert property (
		sChanRd ##0 regSel == tag_pkg::SEL_CTRL
		|=> rdData[tag_pkg::CTRL_APPLY_BIT] == $past(pend[chanIdx]) &&
		(rdData & ~(32'h0000_0001 << tag_pkg::CTRL_APPLY_BIT)) == '0)
		else $error("pending bit read back wrongly");
	a_match_word: assert property (
		sChanRd ##0 regSel == tag_pkg::SEL_MATCH
		|=> rdData == $past(storedMatch[chanIdx]))
		else $error("match word read back wrongly");
	a_pulse_word: assert property (
		sChanRd ##0 regSel == tag_pkg::SEL_PULSE
		|=> rdData == $past(storedPulse[chanIdx]))
		else $error("pulse word read back wrongly");

	// writes land at the taking edge
	a_style_store: assert property (
		sChanWr ##0 regSel == tag_pkg::SEL_CFG
		|=> style[$past(chanIdx)] == $past(wrData[1:0]) &&
		cyclic[$past(chanIdx)] == $past(wrData[tag_pkg::CFG_CYCLIC_BIT]))
		else $error("mode write not stored");
	a_match_store: assert property (
		sChanWr ##0 regSel == tag_pkg::SEL_MATCH
		|=> storedMatch[$past(chanIdx)] == $past(wrData))
		else $error("match write not stored");
	a_pulse_store: assert property (
		sChanWr ##0 regSel == tag_pkg::SEL_PULSE
		|=> storedPulse[$past(chanIdx)] == $past(wrData))
		else $error("pulse write not stored");

	// strobes and the pending flag
	a_arm_shows: assert property (
		sCtrlWr ##0 wrData[tag_pkg::CTRL_ARM_BIT] &&
		!wrData[tag_pkg::CTRL_DISARM_BIT]
		|=> enabledVec[$past(chanIdx)])
		else $error("arm write left the channel disabled");
	a_disarm_shows: assert property (
		sCtrlWr ##0 wrData[tag_pkg::CTRL_DISARM_BIT]
		|=> !enabledVec[$past(chanIdx)] && !alarmOut[$past(chanIdx)])
		else $error("disarm write left the channel running");
	a_pend_set_wins: assert property (
		wrStrobe && chanHit && regSel == tag_pkg::SEL_CTRL &&
		wrData[tag_pkg::CTRL_APPLY_BIT] && enabledVec[chanIdx]
		|=> pend[$past(chanIdx)])
		else $error("apply bit lost on an enabled channel");
	a_pend_inert: assert property (
		sCtrlWr ##0 wrData[tag_pkg::CTRL_APPLY_BIT] &&
		!enabledVec[chanIdx] && !pend[chanIdx]
		|=> !pend[$past(chanIdx)])
		else $error("apply bit set on a disabled channel");
	a_apply_clears: assert property (
		appliedVec != '0 && !wrStrobe
		|=> (pend & $past(appliedVec)) == '0)
		else $error("pending flag kept after it was taken");

	// what the pins show
	a_alarm_enabled: assert property (
		(alarmLvl & ~enabledVec) == '0)
		else $error("alarm high on a disabled channel");
	a_event_edge: assert property (
		alarmEvent == ($past(alarmLvl) & ~$past(alarmLvl, 2)))
		else $error("event does not match an alarm rise");
	a_event_single: assert property (
		(alarmEvent & $past(alarmEvent)) == '0)
		else $error("event lasted more than one cycle");

endmodule
`default_nettype wire

// ---- bench/tag_timer_model.sv ----
// timer model standing in for the general-purpose timer at the far side
// assumes the alarm group samples the count on the same mclk edge
`timescale 1ns/1ns
`default_nettype none
module tag_timer_model #(
	parameter logic [31:0] WRAP = 32'hFFFF_FFFF
) (
	input  wire logic        mclk,    // block clock
	input  wire logic        reset_n, // async reset, active low
	input  wire logic [3:0]  stepDiv, // cycles per count step
	output logic      [31:0] count    // running timer count
);
	logic [3:0] divCnt;
	wire        stepNow = (divCnt + 4'h1) >= stepDiv;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			count  <= 32'h0;
			divCnt <= 4'h0;
		end else if (stepNow) begin
			divCnt <= 4'h0;
			count  <= (count == WRAP) ? 32'h0 : count + 32'h1;
		end else begin
			divCnt <= divCnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the timer alarm group
// assumes the timer model drives the count on the same clock
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        mclk;
	logic        reset_n;
	logic [7:0]  addr;
	logic [31:0] wrData;
	logic        wrStrobe;
	logic        rdStrobe;
	logic [3:0]  stepDiv;
	logic [31:0] timerCount;
	logic [31:0] rdData;
	logic [3:0]  alarmOut;
	logic [3:0]  alarmEvent;
	logic [31:0] prevCnt;
	logic [31:0] base;
	logic [31:0] riseAt [1:4];
	logic [31:0] gap    [1:4];
	logic [31:0] width  [1:4];
	bit          wasHigh[1:4];
	int          rises  [1:4];
	int          events [1:4];
	int          numErrors;
	int          compares;
	int          cycles;
	int          n;

	tag_alarm_group #(.NCH(4)) dut_u (
		.mclk       (mclk),
		.reset_n    (reset_n),
		.addr       (addr),
		.wrData     (wrData),
		.wrStrobe   (wrStrobe),
		.rdStrobe   (rdStrobe),
		.timerCount (timerCount),
		.rdData     (rdData),
		.alarmOut   (alarmOut),
		.alarmEvent (alarmEvent)
	);

	tag_timer_model timer_u (
		.mclk    (mclk),
		.reset_n (reset_n),
		.stepDiv (stepDiv),
		.count   (timerCount)
	);

	always #10 mclk = ~mclk;

	// counts are taken at the falling edge, so gaps and widths come out
	// in timer steps whatever the step rate of the timer model
	always @(negedge mclk) begin
		for (int i = 1; i <= 4; i++) begin
			if (alarmOut[i-1] === 1'b1 && !wasHigh[i]) begin
				gap[i]    = prevCnt - riseAt[i];
				riseAt[i] = prevCnt;
				rises[i]++;
			end
			if (alarmOut[i-1] === 1'b0 && wasHigh[i]) begin
				width[i] = prevCnt - riseAt[i];
			end
			if (alarmEvent[i-1] === 1'b1) begin
				events[i]++;
			end
			wasHigh[i] = (alarmOut[i-1] === 1'b1);
		end
		prevCnt = timerCount;
	end

	task automatic conclude();
		if (numErrors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// a hang in any wait ends the run with a counted mismatch
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			numErrors++;
			conclude();
		end
	end

	function automatic logic [7:0] chAddr(input int ch,
			input logic [1:0] sel);
		return 8'(ch * 16) | {4'h0, sel, 2'h0};
	endfunction

	task automatic chk(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			numErrors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr     <= a;
		wrData   <= d;
		wrStrobe <= 1'b1;
		@(posedge mclk);
		wrStrobe <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
			input string what);
		@(posedge mclk);
		addr     <= a;
		rdStrobe <= 1'b1;
		@(posedge mclk);
		rdStrobe <= 1'b0;
		@(negedge mclk);
		chk(what, rdData, exp);
	endtask

	task automatic idle(input int k);
		repeat (k) @(negedge mclk);
	endtask

	// style and cyclic may only change while disarmed
	task automatic setup(input int ch, input logic [1:0] style,
			input logic cyc, input logic [31:0] mt, input logic [31:0] pl);
		wr(chAddr(ch, tag_pkg::SEL_CTRL), 32'h1 << tag_pkg::CTRL_DISARM_BIT);
		wr(chAddr(ch, tag_pkg::SEL_CFG), {27'h0, cyc, 2'h0, style});
		wr(chAddr(ch, tag_pkg::SEL_MATCH), mt);
		wr(chAddr(ch, tag_pkg::SEL_PULSE), pl);
		wr(chAddr(ch, tag_pkg::SEL_CTRL), 32'h1 << tag_pkg::CTRL_ARM_BIT);
	endtask

	task automatic waitRise(input int ch, input int cnt);
		int target;
		int k;
		target = rises[ch] + cnt;
		k = 0;
		while (rises[ch] < target && k < 3000) begin
			@(negedge mclk);
			k++;
		end
		chk("alarm fired", 32'(rises[ch] >= target), 32'h1);
	endtask

	initial begin
		mclk     = 1'b0;
		reset_n  = 1'b0;
		addr     = 8'h00;
		wrData   = 32'h0;
		wrStrobe = 1'b0;
		rdStrobe = 1'b0;
		stepDiv  = 4'h1;
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		rd(tag_pkg::ADDR_STATUS, 32'h0, "status");
		idle(1);
		chk("read idle", rdData, 32'h0);
		rd(chAddr(1, tag_pkg::SEL_CFG), 32'h0, "cfg");
		rd(chAddr(1, tag_pkg::SEL_MATCH), tag_pkg::RST_MATCH, "match");
		rd(chAddr(4, tag_pkg::SEL_PULSE), tag_pkg::RST_PULSE, "pulse");
		// one count step per cycle, so the answer is one step ahead
		@(negedge mclk);
		n = int'(timerCount);
		rd(tag_pkg::ADDR_COUNT, 32'(n + 1), "count");
		wr(8'h08, 32'hFFFF_FFFF);
		rd(8'h08, 32'h0, "unmapped");
		@(negedge mclk);
		base = timerCount;
		for (int c = 1; c <= 4; c++) begin
			setup(c, tag_pkg::STYLE_ABS, 1'b0, base + 32'(80 + 10 * c),
				32'(c + 1));
		end
		rd(tag_pkg::ADDR_STATUS, 32'hF, "all armed");
		waitRise(4, 1);
		idle(8);
		for (int c = 1; c <= 4; c++) begin
			chk("abs fire", riseAt[c], base + 32'(80 + 10 * c));
			chk("abs width", width[c], 32'(c + 1));
		end
		@(posedge mclk);
		stepDiv <= 4'h2;
		setup(2, tag_pkg::STYLE_REL, 1'b1, 32'h6, 32'h2);
		waitRise(2, 3);
		chk("rel gap", gap[2], 32'h6);
		chk("rel width", width[2], 32'h2);
		setup(2, tag_pkg::STYLE_REL, 1'b0, 32'h6, 32'h2);
		n = rises[2];
		idle(60);
		chk("one-off", 32'(rises[2] - n), 32'h1);
		@(posedge mclk);
		stepDiv <= 4'h1;
		@(negedge mclk);
		base = timerCount + 32'h28;
		setup(3, tag_pkg::STYLE_COMB, 1'b1, base, 32'h3);
		waitRise(3, 2);
		chk("comb first", riseAt[3] - gap[3], base);
		chk("comb gap", gap[3], base);
		wr(chAddr(3, tag_pkg::SEL_CTRL), 32'h1 << tag_pkg::CTRL_DISARM_BIT);
		setup(4, tag_pkg::STYLE_REL, 1'b1, 32'h14, 32'h1);
		waitRise(4, 1);
		wr(chAddr(4, tag_pkg::SEL_MATCH), 32'h1E);
		wr(chAddr(4, tag_pkg::SEL_PULSE), 32'h3);
		rd(chAddr(4, tag_pkg::SEL_MATCH), 32'h1E, "stored match");
		waitRise(4, 1);
		chk("held gap", gap[4], 32'h14);
		wr(chAddr(4, tag_pkg::SEL_CTRL), 32'h1 << tag_pkg::CTRL_APPLY_BIT);
		rd(chAddr(4, tag_pkg::SEL_CTRL), 32'h8000, "pending");
		waitRise(4, 2);
		chk("applied gap", gap[4], 32'h1E);
		chk("applied width", width[4], 32'h3);
		rd(chAddr(4, tag_pkg::SEL_CTRL), 32'h0, "pending done");
		wr(chAddr(4, tag_pkg::SEL_MATCH), 32'hC);
		wr(chAddr(4, tag_pkg::SEL_CTRL), 32'h1 << tag_pkg::CTRL_ARM_BIT);
		waitRise(4, 2);
		chk("restart gap", gap[4], 32'hC);
		wr(chAddr(4, tag_pkg::SEL_CTRL), 32'h1 << tag_pkg::CTRL_DISARM_BIT);
		@(negedge mclk);
		base = timerCount + 32'h20;
		setup(1, tag_pkg::STYLE_ABS, 1'b0, base, 32'h28);
		waitRise(1, 1);
		wr(chAddr(1, tag_pkg::SEL_CTRL), 32'h1 << tag_pkg::CTRL_DISARM_BIT);
		idle(2);
		chk("alarm dropped", {28'h0, alarmOut}, 32'h0);
		rd(tag_pkg::ADDR_STATUS, 32'h2, "after disarm");
		wr(chAddr(1, tag_pkg::SEL_CTRL), 32'h1 << tag_pkg::CTRL_APPLY_BIT);
		rd(chAddr(1, tag_pkg::SEL_CTRL), 32'h0, "apply inert");
		n = rises[1];
		setup(1, tag_pkg::STYLE_RSVD, 1'b1, 32'h4, 32'h2);
		idle(40);
		chk("reserved silent", 32'(rises[1] - n), 32'h0);
		rd(tag_pkg::ADDR_STATUS, 32'h3, "reserved armed");
		for (int c = 1; c <= 4; c++) begin
			chk("events", 32'(events[c]), 32'(rises[c]));
		end
		conclude();
	end
endmodule
`default_nettype wire
